/* rtl/anc_link_ctrl.sv */
// Negotiation, crossover and loopback control of a 10/100/1000 PHY
// Function
// - Receiver link status drives parallel detection
// - Parallel detect sets partner bits 5/7
// - Parallel detect loads selector 00001
// - Expansion bit 0 reads 0 after detect
// - Non-good condition sets parallel fault flag
// - Lost negotiated link restarts negotiation
// - Writing control bit 9 restarts negotiation
// - Restart silences line until break timer
// - Strap disable locks negotiation off
// - Negotiation restarts if not resolved within about three seconds, except while both 10M and 100M links show without pulse bursts
// - Crossover resolves before pulse exchange starts
// - Crossover seed draws from 255 values
// - Crossover also runs at forced 10/100 speed, not at forced 1000
// - MII loop in control, others self-test
// - Loopback availability and link by speed
// - MII loop returns data, optionally to media
// - PCS, digital, analog loop points differ
// - Far-end loop retransmits partner data
`timescale 1ns/1ps
`include "anc_defs.svh"
module anc_link_ctrl #(
    parameter int BREAK_CYC = `ANC_BREAK_MS * `ANC_CLK_KHZ, // Break-link time
    parameter int LFI_CYC   = `ANC_LFI_MS * `ANC_CLK_KHZ,   // Link fail inhibit
    parameter int WDOG_CYC  = `ANC_WDOG_MS * `ANC_CLK_KHZ,  // Negotiation limit
    parameter int MDIX_CYC  = `ANC_MDIX_MS * `ANC_CLK_KHZ   // Crossover slot
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_reg_wr,        // Register write strobe
    input  wire logic              i_reg_rd,        // Register read strobe
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [15:0]       i_reg_wdata,
    output logic      [15:0]       o_reg_rdata,
    input  wire logic              i_strap_an_off,  // Strap: negotiation off
    input  wire logic              i_rx_energy,     // Line energy seen
    input  wire logic              i_link_10,       // 10M receiver link
    input  wire logic              i_link_100,      // 100M receiver link
    input  wire logic              i_link_1000,     // 1000M link good
    input  wire logic              i_partner_flp,   // Partner sends pulse bursts
    input  wire logic              i_page_done,     // Page exchange finished
    input  wire logic [15:0]       i_page_word,     // Partner base page
    input  wire anc_pkg::anc_speed_t i_page_hcd,    // Resolved common speed
    output anc_pkg::anc_speed_t    o_speed,
    output logic                   o_tx_halt,       // Line silent
    output logic                   o_flp_send,      // Send pulse bursts
    output logic                   o_mdix,          // Channels crossed
    output logic                   o_lb_mii,
    output logic                   o_lb_pcs,
    output logic                   o_lb_digital,
    output logic                   o_lb_analog,
    output logic                   o_lb_external,
    output logic                   o_lb_reverse,
    output logic                   o_mii_to_media,  // MII loop also to line
    output logic                   o_rev_to_mac     // Far-end loop also to MAC
);
    import anc_pkg::*;
    localparam int TW = 27;                         // Timer width
    generate
        if (BREAK_CYC < 1 || LFI_CYC < 1 || MDIX_CYC < 1 || WDOG_CYC < 1 ||
            WDOG_CYC >= (1 << TW) || BREAK_CYC >= (1 << TW)) begin : g_chk
            $error("anc_link_ctrl: timer counts out of range");
        end
    endgenerate

    // Pin synchroniser: three stages, change accepted when stages 2 and 3 agree
    logic [5:0] s1, s2, s3, pin;
    logic [5:0] next_pin;
    always_comb begin
        next_pin = pin;
        for (int k = 0; k < 6; k++) begin
            if (s2[k] == s3[k]) begin
                next_pin[k] = s3[k];
            end
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s1  <= 6'h00;
            s2  <= 6'h00;
            s3  <= 6'h00;
            pin <= 6'h00;
        end else begin
            s1  <= {i_strap_an_off, i_rx_energy, i_link_10, i_link_100,
                    i_link_1000, i_partner_flp};
            s2  <= s1;
            s3  <= s2;
            pin <= next_pin;
        end
    end
    wire strap_pin = pin[5];
    wire energy    = pin[4];
    wire l10       = pin[3];
    wire l100      = pin[2];
    wire l1000     = pin[1];
    wire flp       = pin[0];

    // Control state
    anc_state_t state, next_state;
    logic [TW-1:0] tmr, next_tmr;                   // Shared state timer
    logic [15:0] bc, next_bc;                       // Basic control
    logic [15:0] st, next_st;                       // Self-test control
    logic [15:0] lc, next_lc;                       // Loopback config
    logic [15:0] pa, next_pa;                       // Partner ability
    logic        lp_able, next_lp_able;             // Partner negotiated
    logic        pd_flag, next_pd_flag;             // Parallel detect used
    logic        pd_fault, next_pd_fault;           // Sticky fault
    logic        an_cmpl, next_an_cmpl;
    logic        strap_off, next_strap_off;         // Strap caught after reset
    logic [2:0]  strap_cnt, next_strap_cnt;         // Waits out the filter
    anc_speed_t  hcd, next_hcd;
    logic [15:0] next_rdata;
    anc_speed_t  speed;
    logic        link_good, loop_link;
    logic        wr_bc, restart, an_en;

    // Operating speed: forced bits when negotiation is off
    always_comb begin
        if (bc[`ANC_BC_AN_EN]) begin
            speed = hcd;
        end else if (bc[`ANC_BC_SPD1]) begin
            speed = ANC_SPD_1000;
        end else begin
            speed = bc[`ANC_BC_SPD0] ? ANC_SPD_100 : ANC_SPD_10;
        end
        case (speed)
            ANC_SPD_1000: link_good = l1000;
            ANC_SPD_100:  link_good = l100;
            default:      link_good = l10;
        endcase
    end

    assign an_en   = bc[`ANC_BC_AN_EN];
    assign wr_bc   = i_reg_wr && i_reg_addr == `ANC_ADDR_BC;
    assign restart = wr_bc && i_reg_wdata[`ANC_BC_RESTART] && an_en;

    logic mdix_lock;

    // Next values of negotiation, registers and read data
    always_comb begin
        next_state     = state;
        next_tmr       = tmr + 1'b1;
        next_bc        = bc;
        next_st        = st;
        next_lc        = lc;
        next_pa        = pa;
        next_lp_able   = lp_able;
        next_pd_flag   = pd_flag;
        next_pd_fault  = pd_fault;
        next_an_cmpl   = an_cmpl;
        next_hcd       = hcd;
        next_strap_off = strap_off;
        next_strap_cnt = strap_cnt;
        next_rdata     = o_reg_rdata;
        // Strap level taken at the fifth edge: the filtered copy needs four edges
        // to show the pin, and an earlier look would always see the reset zero
        if (strap_cnt != 3'h5) begin
            next_strap_cnt = strap_cnt + 3'h1;
            if (strap_cnt == 3'h4) begin
                next_strap_off = strap_pin;
            end
        end
        // Register writes; the restart bit never stores
        if (wr_bc) begin
            next_bc = i_reg_wdata & ~16'h8200;
        end
        if (i_reg_wr && i_reg_addr == `ANC_ADDR_ST) begin
            next_st = i_reg_wdata;
        end
        if (i_reg_wr && i_reg_addr == `ANC_ADDR_LC) begin
            next_lc = i_reg_wdata;
        end
        if (next_strap_off) begin
            next_bc[`ANC_BC_AN_EN] = 1'b0;
        end
        // Read data; fault flag clears on read
        if (i_reg_rd) begin
            case (i_reg_addr)
                `ANC_ADDR_BC: next_rdata = bc;
                `ANC_ADDR_BS: next_rdata = `ANC_BS_CAPS
                    | (16'(an_cmpl) << `ANC_BS_AN_CMPL)
                    | (16'(!strap_off) << `ANC_BS_AN_ABLE)
                    | (16'(loop_link) << `ANC_BS_LINK);
                `ANC_ADDR_PA: next_rdata = pa;
                `ANC_ADDR_EX: next_rdata = (16'(pd_fault) << `ANC_EX_PD_FAULT)
                    | (16'(lp_able) << `ANC_EX_LP_ABLE);
                `ANC_ADDR_ST: next_rdata = st;
                `ANC_ADDR_LC: next_rdata = lc;
                default:      next_rdata = 16'h0000;
            endcase
            if (i_reg_addr == `ANC_ADDR_EX) begin
                next_pd_fault = 1'b0;
            end
        end
        case (state)
            ANC_DISABLED: begin
                if (an_en) begin
                    next_state = ANC_BREAK;
                    next_tmr   = '0;
                end
            end
            ANC_MDIX: begin
                if (mdix_lock || st[`ANC_ST_MDIX_OFF]) begin
                    next_state = ANC_ABILITY;
                    next_tmr   = '0;
                end
            end
            ANC_BREAK: begin
                if (tmr == TW'(BREAK_CYC - 1)) begin
                    next_state = ANC_MDIX;
                end
            end
            ANC_ABILITY: begin
                if (i_page_done) begin
                    next_pa      = i_page_word;
                    next_lp_able = 1'b1;
                    next_pd_flag = 1'b0;
                    next_hcd     = i_page_hcd;
                    next_state   = ANC_LWAIT;
                    next_tmr     = '0;
                end else if (!flp && (l10 ^ l100)) begin
                    next_pa      = {8'h00, l100, 1'b0, l10, `ANC_PA_SEL};
                    next_lp_able = 1'b0;
                    next_pd_flag = 1'b1;
                    next_hcd     = l100 ? ANC_SPD_100 : ANC_SPD_10;
                    next_state   = ANC_LWAIT;
                    next_tmr     = '0;
                end else if (!flp && l10 && l100) begin
                    next_pd_fault = 1'b1;
                end else if (tmr == TW'(WDOG_CYC - 1)) begin
                    next_state = ANC_BREAK;
                    next_tmr   = '0;
                end
            end
            ANC_LWAIT: begin
                if (link_good) begin
                    next_state   = ANC_GOOD;
                    next_an_cmpl = 1'b1;
                end else if (tmr == TW'(LFI_CYC - 1)) begin
                    next_pd_fault = pd_flag | next_pd_fault;
                    next_state    = ANC_BREAK;
                    next_tmr      = '0;
                end
            end
            ANC_GOOD: begin
                if (!link_good) begin
                    next_state   = ANC_MDIX;
                    next_an_cmpl = 1'b0;
                end
            end
            default: next_state = ANC_DISABLED;
        endcase
        if (restart && state != ANC_DISABLED) begin
            next_state   = ANC_BREAK;
            next_tmr     = '0;
            next_an_cmpl = 1'b0;
        end
        if (!next_bc[`ANC_BC_AN_EN]) begin
            next_state   = ANC_DISABLED;
            next_an_cmpl = 1'b0;
        end
        if (state == ANC_GOOD || state == ANC_DISABLED) begin
            next_tmr = '0;                          // Timer idle here
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state       <= ANC_DISABLED;
            tmr         <= '0;
            bc          <= `ANC_BC_RST;
            st          <= `ANC_ST_RST;
            lc          <= `ANC_LC_RST;
            pa          <= 16'h0000;
            lp_able     <= 1'b0;
            pd_flag     <= 1'b0;
            pd_fault    <= 1'b0;
            an_cmpl     <= 1'b0;
            hcd         <= ANC_SPD_1000;
            strap_off   <= 1'b0;
            strap_cnt   <= 3'h0;
            o_reg_rdata <= 16'h0000;
        end else begin
            state       <= next_state;
            tmr         <= next_tmr;
            bc          <= next_bc;
            st          <= next_st;
            lc          <= next_lc;
            pa          <= next_pa;
            lp_able     <= next_lp_able;
            pd_flag     <= next_pd_flag;
            pd_fault    <= next_pd_fault;
            an_cmpl     <= next_an_cmpl;
            hcd         <= next_hcd;
            strap_off   <= next_strap_off;
            strap_cnt   <= next_strap_cnt;
            o_reg_rdata <= next_rdata;
        end
    end

    // Crossover: maximal 8-bit LFSR walks all 255 nonzero seeds
    logic [7:0]    lfsr, next_lfsr;
    logic [TW-1:0] slot, next_slot;
    logic          mdix, next_mdix, next_lock, mdix_run;
    always_comb begin
        mdix_run  = !mdix_lock && (state == ANC_MDIX ||
                    (state == ANC_DISABLED && speed != ANC_SPD_1000));
        next_lfsr = lfsr;
        next_slot = '0;
        next_mdix = mdix;
        next_lock = mdix_lock;
        if (st[`ANC_ST_MDIX_OFF]) begin
            next_mdix = st[`ANC_ST_MDIX_MAN];       // Manual choice wins
            next_lock = 1'b0;
        end else if (mdix_run) begin
            next_lock = energy;
            next_slot = slot + 1'b1;
            if (slot == TW'(MDIX_CYC - 1)) begin
                next_slot = '0;
                next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
                next_mdix = mdix ^ lfsr[0];
            end
        end else if (state == ANC_BREAK || (!energy && !link_good)) begin
            next_lock = 1'b0;                       // Re-hunt on a new attempt
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            lfsr      <= `ANC_LFSR_SEED;
            slot      <= '0;
            mdix      <= 1'b0;
            mdix_lock <= 1'b0;
        end else begin
            lfsr      <= next_lfsr;
            slot      <= next_slot;
            mdix      <= next_mdix;
            mdix_lock <= next_lock;
        end
    end

    // Loopback selection, gated by speed; one point at a time by encoding
    anc_lb_t lb_code;
    logic [7:0] next_lb, lb;
    always_comb begin
        lb_code = anc_lb_t'(st[`ANC_ST_LB_LSB +: 3]);
        next_lb = 8'h00;
        next_lb[0] = bc[`ANC_BC_LOOP];
        if (!bc[`ANC_BC_LOOP]) begin
            case (lb_code)
                ANC_LB_PCS: next_lb[1] = speed != ANC_SPD_10;
                ANC_LB_DIG: next_lb[2] = 1'b1;
                ANC_LB_ANA: next_lb[3] = 1'b1;
                ANC_LB_EXT: next_lb[4] = speed != ANC_SPD_1000;
                ANC_LB_REV: next_lb[5] = 1'b1;
                default:    next_lb[1] = 1'b0;
            endcase
        end
        next_lb[6] = next_lb[0] && st[`ANC_ST_MII_MEDIA];
        next_lb[7] = next_lb[5] && st[`ANC_ST_REV_MAC];
        // Link indication inside loops
        if (lb[0]) begin
            loop_link = 1'b0;
        end else if (lb[1]) begin
            loop_link = speed == ANC_SPD_100;
        end else if (lb[2] || lb[3]) begin
            loop_link = 1'b1;
        end else begin
            loop_link = link_good;
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            lb <= 8'h00;
        end else begin
            lb <= next_lb;
        end
    end
    assign {o_rev_to_mac, o_mii_to_media, o_lb_reverse, o_lb_external,
            o_lb_analog, o_lb_digital, o_lb_pcs, o_lb_mii} = lb;
    assign o_speed    = speed;
    assign o_mdix     = mdix;
    assign o_tx_halt  = state == ANC_BREAK;
    assign o_flp_send = state == ANC_ABILITY;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_restart_req;
        restart && state != ANC_DISABLED && i_reg_wdata[`ANC_BC_AN_EN];
    endsequence
    a_restart_break: assert property (s_restart_req |=> state == ANC_BREAK)
        else $error("restart did not enter break");
    a_break_quiet: assert property (state == ANC_BREAK |-> o_tx_halt && !o_flp_send)
        else $error("line active during break");
    a_pd_selector: assert property (an_cmpl && pd_flag |-> pa[4:0] == 5'h01)
        else $error("selector wrong after detect");
    a_pd_bits: assert property (an_cmpl && pd_flag |-> pa[7] != pa[5])
        else $error("partner tech bits wrong");
    a_pd_exp0: assert property (an_cmpl && pd_flag |-> !lp_able)
        else $error("expansion bit 0 set after detect");
    a_fault_set: assert property (state == ANC_ABILITY && !i_page_done && !flp && l10
        && l100 |=> pd_fault)
        else $error("fault flag not set");
    a_link_lost: assert property (state == ANC_GOOD && !link_good && !restart && an_en
        && !wr_bc |=> state == ANC_MDIX)
        else $error("lost link not renegotiated");
    a_strap_lock: assert property (strap_off |-> !an_en)
        else $error("strap did not lock negotiation");
    a_one_loop: assert property ($onehot0(lb[5:0]))
        else $error("more than one loop point");
    a_ext_speed: assert property (o_lb_external |-> $past(speed) != ANC_SPD_1000)
        else $error("external loop at gigabit");
endmodule

/* include/anc_defs.svh */
// Register map, field positions, reset values and timing for link control
`ifndef ANC_DEFS_SVH
`define ANC_DEFS_SVH
`define ANC_ADDR_BC      8'h00
`define ANC_ADDR_BS      8'h01
`define ANC_ADDR_PA      8'h05
`define ANC_ADDR_EX      8'h06
`define ANC_ADDR_ST      8'h16
`define ANC_ADDR_LC      8'hfe
`define ANC_BC_LOOP      14
`define ANC_BC_SPD0      13
`define ANC_BC_AN_EN     12
`define ANC_BC_RESTART   9
`define ANC_BC_SPD1      6
`define ANC_BC_RST       16'h1140
`define ANC_BS_CAPS      16'h7900
`define ANC_BS_AN_CMPL   5
`define ANC_BS_AN_ABLE   3
`define ANC_BS_LINK      2
`define ANC_PA_10        5
`define ANC_PA_100       7
`define ANC_PA_SEL       5'h01
`define ANC_EX_LP_ABLE   0
`define ANC_EX_PD_FAULT  4
`define ANC_ST_LB_LSB    0
`define ANC_ST_MII_MEDIA 5
`define ANC_ST_REV_MAC   6
`define ANC_ST_MDIX_OFF  8
`define ANC_ST_MDIX_MAN  9
`define ANC_ST_RST       16'h0000
`define ANC_LC_RST       16'h0000
`define ANC_CLK_KHZ      40000
`define ANC_BREAK_MS     1200
`define ANC_LFI_MS       750
`define ANC_WDOG_MS      3000
`define ANC_MDIX_MS      62
`define ANC_LFSR_SEED    8'h01
`endif

/* include/anc_pkg.sv */
// Types shared by the link control block
package anc_pkg;
    typedef enum logic [5:0] {
        ANC_DISABLED = 6'b00_0001,
        ANC_MDIX     = 6'b00_0010,
        ANC_BREAK    = 6'b00_0100,
        ANC_ABILITY  = 6'b00_1000,
        ANC_LWAIT    = 6'b01_0000,
        ANC_GOOD     = 6'b10_0000
    } anc_state_t;
    typedef enum logic [1:0] {
        ANC_SPD_10   = 2'h0,
        ANC_SPD_100  = 2'h1,
        ANC_SPD_1000 = 2'h2
    } anc_speed_t;
    typedef enum logic [2:0] {
        ANC_LB_NONE = 3'h0,
        ANC_LB_PCS  = 3'h1,
        ANC_LB_DIG  = 3'h2,
        ANC_LB_ANA  = 3'h3,
        ANC_LB_EXT  = 3'h4,
        ANC_LB_REV  = 3'h5
    } anc_lb_t;
endpackage

/* bench/anc_partner_model.sv */
// Link partner model: a plain 10/100 station that never negotiates
`timescale 1ns/1ps
module anc_partner_model (
    input  wire logic [1:0] i_mode,     // 0 quiet, 1 10M, 2 100M, 3 both (bad)
    output logic            o_energy,   // Line energy toward the block
    output logic            o_link_10,  // 10M link pulses valid
    output logic            o_link_100, // 100M idle stream valid
    output logic            o_flp       // Pulse bursts, never sent
);
    // Only link signals, so the block must pick the technology itself
    always_comb begin
        o_energy   = (i_mode != 2'h0);
        o_link_10  = i_mode[0];
        o_link_100 = i_mode[1];
        o_flp      = 1'b0;
    end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the link control block
`timescale 1ns/1ps
module tb_top;
    import anc_pkg::*;
    localparam int BRK = 20;   // Short break-link time keeps the run brief
    logic        i_clk, i_reset, i_reg_wr, i_reg_rd, i_strap_an_off;
    logic [7:0]  i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, rd;
    logic [1:0]  mode;         // Partner behaviour
    logic        energy, l10, l100, flp, o_tx_halt, o_flp_send, o_mdix;
    logic [5:0]  lb;           // mii, pcs, digital, analog, external, reverse
    logic        mii_media, rev_mac, mdix0;
    logic        page_done, link1g;   // Negotiated page exchange, gigabit link
    logic [15:0] page_word;           // Partner base page handed over
    anc_speed_t  page_hcd;            // Common speed handed over
    anc_speed_t  o_speed;
    int          err_total, checked, n;
    anc_partner_model anc_partner_model_i (.i_mode(mode), .o_energy(energy),
        .o_link_10(l10), .o_link_100(l100), .o_flp(flp));
    anc_link_ctrl #(.BREAK_CYC(BRK), .LFI_CYC(40), .WDOG_CYC(200), .MDIX_CYC(8)) anc_link_ctrl_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_strap_an_off(i_strap_an_off), .i_rx_energy(energy), .i_link_10(l10),
        .i_link_100(l100), .i_link_1000(link1g), .i_partner_flp(flp),
        .i_page_done(page_done), .i_page_word(page_word), .i_page_hcd(page_hcd),
        .o_speed(o_speed),
        .o_tx_halt(o_tx_halt), .o_flp_send(o_flp_send), .o_mdix(o_mdix),
        .o_lb_mii(lb[5]), .o_lb_pcs(lb[4]), .o_lb_digital(lb[3]), .o_lb_analog(lb[2]),
        .o_lb_external(lb[1]), .o_lb_reverse(lb[0]), .o_mii_to_media(mii_media),
        .o_rev_to_mac(rev_mac));
    // Free-running 40 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobes are one cycle wide and never re-raised in the same step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_reg_addr  = a;
        i_reg_wdata = d;
        i_reg_wr    = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic rdr(input logic [7:0] a);
        i_reg_addr = a;
        i_reg_rd   = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        rd       = o_reg_rdata;
        @(negedge i_clk);
    endtask
    // Bounded poll of a register field
    task automatic poll(input logic [7:0] a, input logic [15:0] m, input logic [15:0] w);
        for (n = 0; n < 300; n++) begin
            rdr(a);
            if ((rd & m) === w) break;
        end
    endtask
    task automatic do_reset(input logic strap);
        i_reset        = 1'b1;
        i_strap_an_off = strap;
        repeat (5) @(negedge i_clk);
        i_reset = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic t_regs;
        mode = 2'h0;
        do_reset(1'b0);
        rdr(8'h00); chk("bc", rd, 16'h1140);
        rdr(8'h01); chk("bs", rd, 16'h7908);
        wr(8'h05, 16'hffff);
        rdr(8'h05); chk("pa", rd, 16'h0000);
        rdr(8'h16); chk("st", rd, 16'h0000);
        rdr(8'h42); chk("unmapped", rd, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_restart;
        // Write issued inline so the halt count starts at the taking edge
        i_reg_addr  = 8'h00;
        i_reg_wdata = 16'h1340;
        i_reg_wr    = 1'b1;
        n = 0;
        repeat (BRK + 10) begin
            @(negedge i_clk);
            i_reg_wr = 1'b0;
            if (o_tx_halt === 1'b1) n++;
        end
        chk("halt cycles", 16'(n), 16'(BRK));
        chk("flp quiet", {15'h0000, o_flp_send}, 16'h0000);
        rdr(8'h00); chk("bc", rd, 16'h1140);
        $display("test restart done");
    endtask
    task automatic t_pd;
        mode = 2'h2;
        poll(8'h01, 16'h0024, 16'h0024); chk("bs", rd & 16'h0024, 16'h0024);
        rdr(8'h05); chk("pa", rd, 16'h0081);
        rdr(8'h06); chk("ex", rd & 16'h0011, 16'h0000);
        chk("speed", 16'(o_speed), 16'(ANC_SPD_100));
        mode = 2'h0;
        poll(8'h01, 16'h0020, 16'h0000); chk("bs", rd & 16'h0020, 16'h0000);
        mode = 2'h1;
        poll(8'h01, 16'h0020, 16'h0020); chk("bs", rd & 16'h0020, 16'h0020);
        rdr(8'h05); chk("pa", rd, 16'h0021);
        $display("test parallel done");
    endtask
    task automatic t_fault;
        mode = 2'h3;
        wr(8'h00, 16'h1340);
        poll(8'h06, 16'h0010, 16'h0010); chk("fault", rd & 16'h0010, 16'h0010);
        $display("test fault done");
    endtask
    // Still in the ability state: a finished page exchange at gigabit
    task automatic t_page;
        chk("flp", {15'h0000, o_flp_send}, 16'h0001);
        page_word = 16'h41e1;
        page_hcd  = ANC_SPD_1000;
        link1g    = 1'b1;
        page_done = 1'b1;
        @(negedge i_clk);
        page_done = 1'b0;
        poll(8'h01, 16'h0020, 16'h0020); chk("bs", rd & 16'h0020, 16'h0020);
        rdr(8'h05); chk("pa", rd, 16'h41e1);
        rdr(8'h06); chk("ex", rd & 16'h0001, 16'h0001);
        chk("speed", 16'(o_speed), 16'(ANC_SPD_1000));
        link1g = 1'b0;
        $display("test page done");
    endtask
    task automatic t_strap;
        do_reset(1'b1);
        wr(8'h00, 16'h0000);
        wr(8'h00, 16'h1000);
        rdr(8'h00); chk("bc", rd, 16'h0000);
        rdr(8'h01); chk("bs", rd & 16'h0008, 16'h0000);
        chk("halt", {15'h0000, o_tx_halt}, 16'h0000);
        do_reset(1'b0);
        wr(8'h00, 16'h0000);
        wr(8'h00, 16'h1000);
        chk("halt", {15'h0000, o_tx_halt}, 16'h0001);
        $display("test strap done");
    endtask
    task automatic t_loop;
        wr(8'hfe, 16'he720);
        rdr(8'hfe); chk("lc", rd, 16'he720);
        mode = 2'h0;
        wr(8'h00, 16'h2100);
        mdix0 = o_mdix;
        for (n = 0; n < 300 && o_mdix === mdix0; n++) @(negedge i_clk);
        chk("hunt", {15'h0000, o_mdix}, {15'h0000, ~mdix0});
        mode = 2'h2;
        for (int c = 1; c < 6; c++) begin
            wr(8'h16, 16'h0300 | 16'(c));
            chk("lb", {10'h000, lb}, {10'h000, 6'h20 >> c});
        end
        chk("mdix", {15'h0000, o_mdix}, 16'h0001);
        wr(8'h16, 16'h0345); chk("rev", {15'h0000, rev_mac}, 16'h0001);
        wr(8'h00, 16'h6100); chk("mii", {10'h000, lb}, 16'h0020);
        wr(8'h16, 16'h0320); chk("media", {15'h0000, mii_media}, 16'h0001);
        rdr(8'h01); chk("link", rd & 16'h0004, 16'h0000);
        wr(8'h00, 16'h0140);
        wr(8'h16, 16'h0304); chk("ext1g", {10'h000, lb}, 16'h0000);
        wr(8'h00, 16'h0100);
        wr(8'h16, 16'h0301); chk("pcs10", {10'h000, lb}, 16'h0000);
        $display("test loopback done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, far above the expected run length
    initial begin
        repeat (30000) @(posedge i_clk);
        err_total++;
        tally_and_finish;
    end
    initial begin
        {i_reset, i_reg_wr, i_reg_rd, i_strap_an_off, mode} = '0;
        {i_reg_addr, i_reg_wdata, err_total, checked} = '0;
        {page_done, link1g, page_word} = '0;
        page_hcd = ANC_SPD_10;
        t_regs;
        t_restart;
        t_pd;
        t_fault;
        t_page;
        t_strap;
        t_loop;
        tally_and_finish;
    end
endmodule
